// ===== pkg/ata_cmd_pkg.sv
// constants for the ata command decoder
package ata_cmd_pkg;
   // register offsets, byte addresses
   localparam logic [5:0] OFS_DATA = 6'h00;
   localparam logic [5:0] OFS_ERRFEAT = 6'h04;
   localparam logic [5:0] OFS_SCOUNT = 6'h08;
   localparam logic [5:0] OFS_SNUM = 6'h0C;
   localparam logic [5:0] OFS_CYL_LO = 6'h10;
   localparam logic [5:0] OFS_CYL_HI = 6'h14;
   localparam logic [5:0] OFS_DRVHD = 6'h18;
   localparam logic [5:0] OFS_STATCMD = 6'h1C;
   localparam logic [5:0] OFS_ALTCTL = 6'h20;
   // status, error, control, drive/head bits
   localparam int ST_BSY = 7;
   localparam int ST_DRDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_ABRT = 2;
   localparam int CTL_SRST = 2;
   localparam int CTL_INTERRUPT_DISABLE_BIT = 1;
   localparam int DH_DRV = 4;
   localparam int DH_LBA = 6;
   localparam logic [7:0] SN_RESET = 8'h01;
   localparam logic [7:0] DH_RESET = 8'hA0;
   localparam logic [7:0] PWR_ACTIVE = 8'hFF;
   localparam logic [7:0] PWR_STANDBY = 8'h00;
   localparam logic [7:0] DIAG_PASS = 8'h01;
   // index of the last word in a sector, normal and long
   localparam logic [8:0] LAST_WORD = 9'h0FF;
   localparam logic [8:0] LAST_WORD_LONG = 9'h101;
   // identify block
   localparam logic [15:0] ID_CFG_REMOVABLE = 16'h848A;
   localparam logic [15:0] ID_CFG_FIXED = 16'h044A;
   localparam logic [15:0] ID_BUF_TYPE = 16'h0002;
   localparam logic [15:0] ID_BUF_SIZE = 16'h0002;
   localparam logic [15:0] ID_ECC_BYTES = 16'h0004;
   localparam logic [15:0] ID_MAX_MULT = 16'h0001;
   localparam logic [15:0] ID_DWORD = 16'h0000;
   localparam logic [15:0] ID_CAPS = 16'h0200;
   localparam logic [15:0] ID_PIO_MODE = 16'h0200;
   localparam logic [15:0] ID_VALID = 16'h0003;
   localparam logic [15:0] ID_MULT_VALID = 16'h0100;
   localparam logic [15:0] ID_ADV_PIO = 16'h0003;
   localparam logic [15:0] ID_PIO_CYCLE = 16'h0078;
   localparam logic [15:0] ID_SPACE2 = 16'h2020;
   // default geometry and capacity, plain values
   localparam logic [15:0] GEO_CYLS = 16'h0100;
   localparam logic [7:0] GEO_HEADS = 8'h04;
   localparam logic [7:0] GEO_SPT = 8'h20;
   localparam logic [31:0] CARD_SECTORS = 32'h0000_8000;
   // internal operation classes
   typedef enum logic [4:0] {
      OP_NOP, OP_PWR_CHK, OP_DIAG, OP_ERASE, OP_FORMAT, OP_IDENT, OP_IDLE,
      OP_IDLE_IMM, OP_INIT, OP_RD_BUF, OP_RD_MULT, OP_RD_LONG, OP_RD,
      OP_VERIFY, OP_STBY, OP_SLEEP, OP_SET_FEAT, OP_SET_MULT, OP_WEAR,
      OP_WR_BUF, OP_WR_LONG, OP_WR, OP_BAD
   } op_e;
endpackage

// ===== src/ata_command_decoder.sv
// ata task file, command decoder and executor behind a wishbone slave
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/100ps
module ata_command_decoder (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        fixed_disk_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             interrupt_request_out_o,
   output logic             auto_pwr_down_o
);
   import ata_cmd_pkg::*;

   typedef enum logic [4:0] {
      S_READY = 5'b00001,
      S_EXEC  = 5'b00010,
      S_OUT   = 5'b00100,
      S_IN    = 5'b01000,
      S_SECT  = 5'b10000
   } state_e;

   // ******************************************
   // decode
   // ******************************************
   function automatic op_e decode(input logic [7:0] c);
      op_e o;
      o = OP_BAD;
      case (c) inside
         8'hE5, 8'h98: o = OP_PWR_CHK;
         8'h90: o = OP_DIAG;
         8'hC0: o = OP_ERASE;
         8'h50: o = OP_FORMAT;
         8'hEC: o = OP_IDENT;
         8'hE3, 8'h97: o = OP_IDLE;
         8'hE1, 8'h95: o = OP_IDLE_IMM;
         8'h91: o = OP_INIT;
         8'hE4: o = OP_RD_BUF;
         8'hC4: o = OP_RD_MULT;
         8'h22, 8'h23: o = OP_RD_LONG;
         8'h20, 8'h21: o = OP_RD;
         8'h40, 8'h41: o = OP_VERIFY;
         8'h1?, 8'h03, 8'h7?, 8'h87: o = OP_NOP;
         8'hEF: o = OP_SET_FEAT;
         8'hC6: o = OP_SET_MULT;
         8'hE6, 8'h99: o = OP_SLEEP;
         8'hE2, 8'h96, 8'hE0, 8'h94: o = OP_STBY;
         8'hF5: o = OP_WEAR;
         8'hE8: o = OP_WR_BUF;
         8'h32, 8'h33: o = OP_WR_LONG;
         8'h30, 8'h31, 8'h38, 8'h3C, 8'hC5, 8'hCD: o = OP_WR;
         default: o = OP_BAD;
      endcase
      return o;
   endfunction

   function automatic logic is_addr(input logic [5:0] a, input logic [5:0] r);
      return a == r;
   endfunction

   logic        ack_q;
   logic [31:0] rdat_q;
   logic        irq_q;
   logic        apd_q;
   logic [7:0]  feat_q, sc_q, sn_q, cyl_lo_q, cyl_hi_q, dh_q, err_q;
   logic        interrupt_disable_bit_q, srst_q, fixed_q, strap_done_q;
   logic        fd_s1_q, fd_s2_q, fd_s3_q;
   logic [7:0]  spt_q, heads_q, mult_q, pwr_q;
   logic        pend_q, drq_q, errst_q;
   state_e      state_q;
   op_e         op_q;
   logic [8:0]  word_q;
   logic [8:0]  sec_left_q;
   logic [7:0]  blk_left_q;
   logic [15:0] buf_q [256];
   logic [15:0] id_word;
   logic [15:0] out_word;

   wire acc    = wb_cyc_i & wb_stb_i & ~ack_q;
   wire wr     = acc & wb_we_i;
   wire rd     = acc & ~wb_we_i;
   wire cmd_wr = wr & is_addr(wb_adr_i, OFS_STATCMD) & wb_sel_i[0] & ~srst_q
                 & state_q == S_READY;
   wire st_rd  = rd & is_addr(wb_adr_i, OFS_STATCMD);
   wire dat_rd = rd & is_addr(wb_adr_i, OFS_DATA) & state_q == S_OUT;
   wire dat_wr = wr & is_addr(wb_adr_i, OFS_DATA) & state_q == S_IN;
   wire tf_wr  = wr & state_q == S_READY & wb_sel_i[0];
   wire long_x = op_q == OP_RD_LONG || op_q == OP_WR_LONG;
   wire [8:0] last_w = long_x ? LAST_WORD_LONG : LAST_WORD;
   wire word_end = word_q == last_w;
   wire [31:0] cur_cap = 32'(cyl_lo_q) * 32'(heads_q) * 32'(spt_q);

   // ******************************************
   // wishbone slave
   // ******************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   always_comb begin
      out_word = op_q == OP_IDENT ? id_word : buf_q[word_q[7:0]];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (rd) begin
         rdat_q <= 32'h0000_0000;
         case (wb_adr_i)
            OFS_DATA:    rdat_q[15:0] <= state_q == S_OUT ? out_word : 16'h0000;
            OFS_ERRFEAT: rdat_q[7:0] <= err_q;
            OFS_SCOUNT:  rdat_q[7:0] <= sc_q;
            OFS_SNUM:    rdat_q[7:0] <= sn_q;
            OFS_CYL_LO:  rdat_q[7:0] <= cyl_lo_q;
            OFS_CYL_HI:  rdat_q[7:0] <= cyl_hi_q;
            OFS_DRVHD:   rdat_q[7:0] <= dh_q;
            OFS_STATCMD, OFS_ALTCTL: begin
               rdat_q[ST_BSY]  <= state_q == S_EXEC || state_q == S_SECT || srst_q;
               rdat_q[ST_DRDY] <= state_q != S_EXEC && !srst_q;
               rdat_q[ST_DSC]  <= 1'b1;
               rdat_q[ST_DRQ]  <= drq_q;
               rdat_q[ST_ERR]  <= errst_q;
            end
            default: rdat_q <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ******************************************
   // strap and device control
   // ******************************************
   // strap pin passes three flops; taken once the last two agree
   always_ff @(posedge clk_i) begin
      fd_s1_q <= fixed_disk_i;
      fd_s2_q <= fd_s1_q;
      fd_s3_q <= fd_s2_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_done_q <= 1'b0;
         fixed_q      <= 1'b0;
      end else if (!strap_done_q && fd_s2_q == fd_s3_q) begin
         strap_done_q <= 1'b1;
         fixed_q      <= fd_s3_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         interrupt_disable_bit_q <= 1'b0;
         srst_q <= 1'b0;
      end else if (wr & is_addr(wb_adr_i, OFS_ALTCTL) & wb_sel_i[0]) begin
         interrupt_disable_bit_q <= wb_dat_i[CTL_INTERRUPT_DISABLE_BIT];
         srst_q <= wb_dat_i[CTL_SRST];
      end
   end

   // ******************************************
   // command sequencer
   // ******************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || srst_q) begin
         state_q <= S_READY;
         op_q <= OP_NOP;
         word_q <= 9'h000;
         sec_left_q <= 9'h000;
         blk_left_q <= 8'h00;
         drq_q <= 1'b0;
         errst_q <= 1'b0;
         err_q <= DIAG_PASS;
         pend_q <= 1'b0;
      end else begin
         if (st_rd || cmd_wr) begin
            pend_q <= 1'b0;
         end
         case (state_q)
            S_READY: begin
               if (cmd_wr) begin
                  op_q <= decode(wb_dat_i[7:0]);
                  sec_left_q <= {sc_q == 8'h00, sc_q};
                  blk_left_q <= 8'h00;
                  word_q <= 9'h000;
                  errst_q <= 1'b0;
                  err_q <= 8'h00;
                  state_q <= S_EXEC;
               end
            end
            S_EXEC: begin
               state_q <= S_READY;
               pend_q <= 1'b1;
               case (op_q)
                  OP_BAD: begin
                     errst_q <= 1'b1;
                     err_q[ER_ABRT] <= 1'b1;
                  end
                  OP_DIAG: err_q <= DIAG_PASS;
                  OP_IDENT, OP_RD_BUF: begin
                     sec_left_q <= 9'h001;
                     drq_q <= 1'b1;
                     state_q <= S_OUT;
                  end
                  OP_RD, OP_RD_LONG, OP_RD_MULT: begin
                     drq_q <= 1'b1;
                     blk_left_q <= mult_q - 8'h01;
                     state_q <= S_OUT;
                  end
                  OP_VERIFY: pend_q <= 1'b1;
                  OP_FORMAT, OP_WR_BUF: begin
                     sec_left_q <= 9'h001;
                     drq_q <= 1'b1;
                     pend_q <= 1'b0;
                     state_q <= S_IN;
                  end
                  OP_WR, OP_WR_LONG: begin
                     drq_q <= 1'b1;
                     pend_q <= 1'b0;
                     state_q <= S_IN;
                  end
                  default: pend_q <= 1'b1;
               endcase
            end
            S_OUT, S_IN: begin
               if (dat_rd || dat_wr) begin
                  word_q <= word_end ? 9'h000 : word_q + 9'h001;
                  if (word_end) begin
                     sec_left_q <= sec_left_q - 9'h001;
                     drq_q <= 1'b0;
                     state_q <= S_SECT;
                     if (state_q == S_IN) begin
                        pend_q <= 1'b1;
                     end
                  end
               end
            end
            S_SECT: begin
               if (sec_left_q == 9'h000) begin
                  state_q <= S_READY;
               end else begin
                  drq_q <= 1'b1;
                  state_q <= state_q == S_SECT && op_q >= OP_WR_BUF ? S_IN : S_OUT;
                  if (op_q < OP_WR_BUF && blk_left_q == 8'h00) begin
                     pend_q <= 1'b1;
                     blk_left_q <= mult_q - 8'h01;
                  end else if (op_q < OP_WR_BUF) begin
                     blk_left_q <= blk_left_q - 8'h01;
                  end
               end
            end
            default: state_q <= S_READY;
         endcase
      end
   end

   // ******************************************
   // task file registers and settings
   // ******************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || srst_q) begin
         feat_q <= 8'h00;
         sc_q <= 8'h01;
         sn_q <= SN_RESET;
         cyl_lo_q <= 8'h00;
         cyl_hi_q <= 8'h00;
         dh_q <= DH_RESET;
      end else if (state_q == S_EXEC && op_q == OP_PWR_CHK) begin
         sc_q <= pwr_q;
      end else if (state_q == S_EXEC && op_q == OP_WEAR) begin
         sc_q <= 8'h00;
      end else if (tf_wr) begin
         case (wb_adr_i)
            OFS_ERRFEAT: feat_q <= wb_dat_i[7:0];
            OFS_SCOUNT:  sc_q <= wb_dat_i[7:0];
            OFS_SNUM:    sn_q <= wb_dat_i[7:0];
            OFS_CYL_LO:  cyl_lo_q <= wb_dat_i[7:0];
            OFS_CYL_HI:  cyl_hi_q <= wb_dat_i[7:0];
            OFS_DRVHD:   dh_q <= wb_dat_i[7:0];
            default:     feat_q <= feat_q;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spt_q <= GEO_SPT;
         heads_q <= GEO_HEADS;
         mult_q <= 8'h01;
         pwr_q <= PWR_ACTIVE;
         apd_q <= 1'b0;
      end else if (state_q == S_EXEC) begin
         case (op_q)
            OP_INIT: begin
               spt_q <= sc_q;
               heads_q <= {4'h0, dh_q[3:0]} + 8'h01;
            end
            OP_SET_MULT: mult_q <= sc_q == 8'h00 ? 8'h01 : sc_q;
            OP_IDLE: begin
               pwr_q <= PWR_ACTIVE;
               apd_q <= sc_q != 8'h00;
            end
            OP_IDLE_IMM: pwr_q <= PWR_ACTIVE;
            OP_STBY, OP_SLEEP: pwr_q <= PWR_STANDBY;
            default: pwr_q <= pwr_q;
         endcase
      end
   end

   assign auto_pwr_down_o = apd_q;

   // sector buffer; format track leaves it unchanged
   always_ff @(posedge clk_i) begin
      if (dat_wr && op_q != OP_FORMAT && !word_q[8]) begin
         buf_q[word_q[7:0]] <= wb_dat_i[15:0];
      end
   end

   // ******************************************
   // identify block
   // ******************************************
   always_comb begin
      id_word = 16'h0000;
      case (word_q[7:0])
         8'd0:  id_word = fixed_q ? ID_CFG_FIXED : ID_CFG_REMOVABLE;
         8'd1:  id_word = GEO_CYLS;
         8'd3:  id_word = {8'h00, GEO_HEADS};
         8'd6:  id_word = {8'h00, GEO_SPT};
         8'd7:  id_word = CARD_SECTORS[31:16];
         8'd8:  id_word = CARD_SECTORS[15:0];
         8'd19: id_word = "01";
         8'd20: id_word = ID_BUF_TYPE;
         8'd21: id_word = ID_BUF_SIZE;
         8'd22: id_word = ID_ECC_BYTES;
         8'd23: id_word = "RE";
         8'd24: id_word = "V1";
         8'd27: id_word = "AT";
         8'd28: id_word = "A ";
         8'd29: id_word = "CA";
         8'd30: id_word = "RD";
         8'd47: id_word = ID_MAX_MULT;
         8'd48: id_word = ID_DWORD;
         8'd49: id_word = ID_CAPS;
         8'd51: id_word = ID_PIO_MODE;
         8'd53: id_word = ID_VALID;
         8'd54: id_word = {cyl_hi_q, cyl_lo_q};
         8'd55: id_word = {8'h00, heads_q};
         8'd56: id_word = {8'h00, spt_q};
         8'd57: id_word = cur_cap[15:0];
         8'd58: id_word = cur_cap[31:16];
         8'd59: id_word = ID_MULT_VALID | {8'h00, mult_q};
         8'd60: id_word = CARD_SECTORS[15:0];
         8'd61: id_word = CARD_SECTORS[31:16];
         8'd64: id_word = ID_ADV_PIO;
         8'd67, 8'd68: id_word = ID_PIO_CYCLE;
         default: begin
            if (word_q[7:0] >= 8'd10 && word_q[7:0] <= 8'd18) begin
               id_word = ID_SPACE2;
            end else if (word_q[7:0] >= 8'd25 && word_q[7:0] <= 8'd46) begin
               id_word = ID_SPACE2;
            end
         end
      endcase
   end

   // ******************************************
   // interrupt request
   // ******************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= pend_q & ~interrupt_disable_bit_q;
      end
   end

   assign interrupt_request_out_o = irq_q;

   // ******************************************
   // checks
   // ******************************************
   chk_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
      interrupt_disable_bit_q |=> !interrupt_request_out_o)
      else $error("interrupt seen while disabled");
   chk_bad_abort: assert property (@(posedge clk_i) disable iff (rst_i || srst_q)
      state_q == S_EXEC && op_q == OP_BAD |=> errst_q && err_q[ER_ABRT] && pend_q)
      else $error("unknown code not aborted");
   chk_verify_nodrq: assert property (@(posedge clk_i) disable iff (rst_i || srst_q)
      state_q == S_EXEC && op_q == OP_VERIFY |=> !drq_q [*2])
      else $error("verify raised drq");
   chk_idle_apd: assert property (@(posedge clk_i) disable iff (rst_i || srst_q)
      state_q == S_EXEC && op_q == OP_IDLE |=> auto_pwr_down_o == ($past(sc_q) != 8'h00))
      else $error("auto power down wrong");
   chk_init_geo: assert property (@(posedge clk_i) disable iff (rst_i || srst_q)
      state_q == S_EXEC && op_q == OP_INIT |=> spt_q == $past(sc_q))
      else $error("geometry not stored");
   chk_ident_word0: assert property (@(posedge clk_i) disable iff (rst_i || srst_q)
      dat_rd && op_q == OP_IDENT && word_q == 9'h000 |=>
      wb_dat_o[15:0] == (fixed_q ? 16'h044A : 16'h848A))
      else $error("identify word 0 wrong");
   chk_long_len: assert property (@(posedge clk_i) disable iff (rst_i || srst_q)
      state_q == S_OUT && op_q == OP_RD_LONG |-> word_q <= 9'd257)
      else $error("long sector overran");
   chk_count_zero: assert property (@(posedge clk_i) disable iff (rst_i || srst_q)
      cmd_wr && sc_q == 8'h00 |=> sec_left_q == 9'd256)
      else $error("zero count not 256");
   chk_cmd_done: assert property (@(posedge clk_i) disable iff (rst_i || srst_q)
      cmd_wr && wb_dat_i[7:4] == 4'h1 |=> ##1 state_q == S_READY && !errst_q)
      else $error("no-op not completed");
endmodule

// ===== test/host_model.sv
// host side wishbone master model for the task file
`timescale 1ns/100ps
module host_model (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] rdat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [5:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      wdat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 6'h3F;
      sel_o = 4'hF;
      wdat_o = 32'h0000_0000;
   end

   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      wdat_o <= d;
      do begin
         @(posedge clk_i);
      end while (ack_i !== 1'b1);
      r = rdat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      wdat_o <= ~d;
   endtask
endmodule

// ===== test/tb.sv
// self-checking bench for the ata command decoder
`timescale 1ns/100ps
module tb;
   import ata_cmd_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        fixed_disk_i = 1'b0;
   logic        cyc, stb, we, ack, irq, apd;
   logic [5:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q, v;
   logic [16:0] e;
   logic [16:0] notes[$];
   logic [15:0] pat[256];
   logic [7:0]  nd[11];
   int          num_errors = 0;
   int          tests_run = 0;
   int          seed = 82297;
   int          cycles = 0;

   initial begin
      forever #4 clk_i = ~clk_i;
   end

   ata_command_decoder dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .fixed_disk_i(fixed_disk_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .interrupt_request_out_o(irq), .auto_pwr_down_o(apd));

   host_model host_u (
      .clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));

   // ***************************
   // tasks
   // ***************************
   task automatic wrap_up();
      if (num_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      host_u.xfer(1'b1, a, {16'h0000, d}, q);
   endtask

   task automatic rd(input logic [5:0] a, input logic c, input logic [15:0] x);
      notes.push_back({c, x});
      host_u.xfer(1'b0, a, 32'h0000_0000, q);
   endtask

   task automatic wait_rdy();
      do begin
         rd(OFS_ALTCTL, 1'b0, 16'h0000);
      end while (q[ST_BSY] !== 1'b0);
   endtask

   task automatic cmd(input logic [7:0] c);
      wr(OFS_STATCMD, {8'h00, c});
      wait_rdy();
   endtask

   task automatic rd_words(input int n, input logic c);
      for (int i = 0; i < n; i++) begin
         rd(OFS_DATA, c, pat[i % 256]);
         wait_rdy();
      end
   endtask

   function automatic logic [16:0] id_exp(input int i);
      case (i)
         7: return {1'b1, CARD_SECTORS[31:16]};
         8: return {1'b1, CARD_SECTORS[15:0]};
         19: return 17'h1_3031;
         20, 21: return 17'h1_0002;
         22: return 17'h1_0004;
         23: return 17'h1_5245;
         24: return 17'h1_5631;
         25, 26, 31, 46: return 17'h1_2020;
         27: return 17'h1_4154;
         47: return 17'h1_0001;
         48, 52, 58, 63, 65, 66: return 17'h1_0000;
         49, 51: return 17'h1_0200;
         53, 64: return 17'h1_0003;
         55: return 17'h1_0004;
         56: return 17'h1_0020;
         57: return 17'h1_0100;
         59: return 17'h1_0101;
         67, 68: return 17'h1_0078;
         default: return 17'h0_0000;
      endcase
   endfunction

   task automatic ident(input logic [15:0] w0);
      cmd(8'hEC);
      check("irq", {15'h0000, irq}, 16'h0001);
      for (int i = 0; i < 256; i++) begin
         e = id_exp(i);
         rd(OFS_DATA, i == 0 || (e[16] && w0 == ID_CFG_REMOVABLE), i == 0 ? w0 : e[15:0]);
         wait_rdy();
      end
      rd(OFS_STATCMD, 1'b1, 16'h0050);
   endtask

   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
         if (notes[0][16]) begin
            check("read data", rdat[15:0], notes[0][15:0]);
         end
         notes.delete(0);
      end
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ***************************
   // sequence
   // ***************************
   initial begin
      nd = '{8'hE1, 8'h95, 8'h10, 8'h40, 8'h41, 8'h90, 8'h03, 8'h70, 8'hEF, 8'hC0, 8'hE0};
      v = $random(seed);
      nd[2] = 8'h10 | {4'h0, v[3:0]};
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFS_STATCMD, 1'b1, 16'h0050);
      rd(6'h3C, 1'b1, 16'h0000);
      // parameters go in while ready, command last
      wr(OFS_SCOUNT, 16'h0020);
      wr(OFS_DRVHD, 16'h00A3);
      cmd(8'h91);
      wr(OFS_SCOUNT, 16'h0001);
      cmd(8'hC6);
      wr(OFS_CYL_LO, 16'h0002);
      ident(ID_CFG_REMOVABLE);
      wr(OFS_SCOUNT, v[15:0] | 16'h0001);
      cmd(8'hE3);
      check("apd", {15'h0000, apd}, 16'h0001);
      wr(OFS_SCOUNT, 16'h0000);
      cmd(8'h97);
      check("apd", {15'h0000, apd}, 16'h0000);
      cmd(8'hE5);
      rd(OFS_SCOUNT, 1'b1, 16'h00FF);
      wr(OFS_SCOUNT, 16'h0001);
      foreach (nd[i]) begin
         cmd(nd[i]);
         check("irq", {15'h0000, irq}, 16'h0001);
         rd(OFS_STATCMD, 1'b1, 16'h0050);
      end
      cmd(8'h98);
      rd(OFS_SCOUNT, 1'b1, 16'h0000);
      wr(OFS_ALTCTL, 16'h000A);
      cmd(nd[2]);
      check("irq", {15'h0000, irq}, 16'h0000);
      wr(OFS_ALTCTL, 16'h0008);
      cmd(8'hFF);
      check("irq", {15'h0000, irq}, 16'h0001);
      rd(OFS_ERRFEAT, 1'b1, 16'h0004);
      rd(OFS_STATCMD, 1'b1, 16'h0051);
      foreach (pat[i]) begin
         v = $random(seed);
         pat[i] = v[15:0];
      end
      cmd(8'hE8);
      foreach (pat[i]) begin
         wr(OFS_DATA, pat[i]);
         wait_rdy();
      end
      // host supplies one sector after the format command
      cmd(8'h50);
      foreach (pat[i]) begin
         wr(OFS_DATA, ~pat[i]);
         wait_rdy();
      end
      rd(OFS_STATCMD, 1'b1, 16'h0050);
      cmd(8'hE4);
      rd_words(256, 1'b1);
      wr(OFS_SCOUNT, 16'h0002);
      cmd(8'h20);
      rd_words(256, 1'b0);
      rd(OFS_STATCMD, 1'b1, 16'h0058);
      rd_words(256, 1'b0);
      rd(OFS_STATCMD, 1'b1, 16'h0050);
      wr(OFS_SCOUNT, 16'h0001);
      cmd(8'h22);
      rd_words(256, 1'b0);
      rd(OFS_STATCMD, 1'b1, 16'h0058);
      rd_words(2, 1'b0);
      rd(OFS_STATCMD, 1'b1, 16'h0050);
      fixed_disk_i <= 1'b1;
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      ident(ID_CFG_FIXED);
      // let the watcher take the last read before the verdict
      @(posedge clk_i);
      wrap_up();
   end
endmodule
